// ==== test/ldc_apb_host.sv ====
// apb master standing in for the controller
// assumes each call starts just after a rising edge
module ldc_apb_host (
   input  wire logic        CLK, PREADY, PSLVERR,
   input  wire logic [31:0] PRDATA,
   output logic             PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0,
   output logic [11:0]      PADDR = '0,
   output logic [31:0]      PWDATA = '0
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // transfer
   // ****
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
      @(posedge CLK) PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      e = PSLVERR;
      q = PRDATA;
      // released data flips so a stale word cannot pass as live
      {PSEL, PENABLE, PWDATA} <= {2'b00, ~d};
      // one idle edge keeps the next call from re-raising psel at once
      @(posedge CLK);
   endtask
endmodule

// ==== test/ldc_monitor.sv ====
// port checker for ldc_top
// assumes it is bound to ldc_top
module ldc_monitor (
   input wire logic        CLK, RST_N, PSEL, PENABLE, PWRITE, RANGE_HIGH,
   input wire logic        EMITTER_ENABLE_LOW, LASER_SETTING_VALID_FLAG,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [7:0]  DAC_CODE,
   input wire logic [8:0]  DAC_REL_NUM
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // checks
   // ****
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire w  = PSEL && PENABLE && PWRITE;
   wire ok = LASER_SETTING_VALID_FLAG;
   code_load_a: assert property (w && PADDR == 12'h070 |=>
      DAC_CODE == $past(PWDATA[7:0])) else $error("code lost");
   rel_step_a: assert property (DAC_REL_NUM == 9'h081 + DAC_CODE)
      else $error("bad step");
   pair_bad_a: assert property (w && PADDR == 12'h074 &&
      PWDATA[7:0] != ~DAC_CODE |=> ##1 !ok && EMITTER_ENABLE_LOW)
      else $error("laser on");
   valid_src_a: assert property ($rose(ok) |-> $past(w, 2))
      else $error("stray valid");
   range_bad_a: assert property (w && PADDR == 12'h068 && ok &&
      PWDATA[7] != RANGE_HIGH |=> ##1 !ok) else $error("range kept");
   force_off_a: assert property (w && PADDR == 12'h068 && PWDATA[0]
      |=> ##1 EMITTER_ENABLE_LOW) else $error("laser not forced off");
   cover property ($rose(ok));
   cover property ($fell(ok));
   cover property (w && PADDR == 12'h068);
endmodule
bind ldc_top ldc_monitor u_mon (.*);

// ==== test/tb_top.sv ====
// bench for ldc_top, bus traffic through ldc_apb_host
// assumes the handed-over reset values and read timing
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // ****
   // scenarios
   // ****
   logic        CLK = 1'b0, RST_N = 1'b0, PSEL, PENABLE, PWRITE, PREADY;
   logic        EMITTER_ENABLE_LOW, RANGE_HIGH, LASER_SETTING_VALID_FLAG;
   logic        PSLVERR, e;
   logic [31:0] PWDATA, PRDATA, q;
   logic [11:0] PADDR;
   logic [8:0]  DAC_REL_NUM;
   logic [7:0]  DAC_CODE;
   logic [2:0]  CALIBRATION_SELECT;
   int          miscompares = 0, tests_run = 0;
   ldc_top DUT (.*);
   ldc_apb_host h (.*);
   initial forever #12.5 CLK = ~CLK;
   initial #50us begin miscompares++; give_verdict; end
   task automatic chk(input logic [31:0] g, x);
      tests_run++;
      if (g !== x) $display("BAD %0t got %h want %h", $time, g, x);
      miscompares += (g !== x);
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      h.xfer(1'b1, a, {24'h0, d}, q, e);
   endtask
   task automatic look(input logic [7:0] c, input logic v);
      @(posedge CLK);
      chk(DAC_CODE, c);
      chk(DAC_REL_NUM, 9'h081 + c);
      chk({LASER_SETTING_VALID_FLAG, EMITTER_ENABLE_LOW}, {v, !v});
   endtask
   task automatic t_order;
      h.xfer(1'b0, 12'h074, '0, q, e);
      chk(q, '0);
      look(8'h00, 1'b0);
      wr(12'h07C, 8'hA0);
      wr(12'h070, 8'h5A);
      wr(12'h074, 8'hA5);
      look(8'h5A, 1'b1);
      wr(12'h074, 8'h00);
      wr(12'h070, 8'hFF);
      look(8'hFF, 1'b1);
   endtask
   task automatic t_fault;
      wr(12'h074, 8'h01);
      look(8'hFF, 1'b0);
      wr(12'h074, 8'h00);
      wr(12'h068, 8'h80);
      look(8'hFF, 1'b0);
      wr(12'h07C, 8'h00);
      wr(12'h068, 8'h8F);
      @(posedge CLK);
      chk({LASER_SETTING_VALID_FLAG, EMITTER_ENABLE_LOW}, 2'b11);
      chk(RANGE_HIGH, 1'b1);
      chk(CALIBRATION_SELECT, 3'h7);
      h.xfer(1'b0, 12'h008, '0, q, e);
      chk(q, 32'h00000040);
      h.xfer(1'b0, 12'h070, '0, q, e);
      chk(q, 32'h000000FF);
      chk(e, 1'b0);
      h.xfer(1'b1, 12'h7F0, '0, q, e);
      chk(e, 1'b1);
   endtask
   task automatic give_verdict;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      t_order;
      t_fault;
      give_verdict;
   end
endmodule

// ==== verilog/ldc_cmp_check.sv ====
// one value / complement pair checker
// assumes both inputs come from registers on the same clock
module ldc_cmp_check #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] value,
   input  wire logic [W-1:0] inverse,
   output logic              match
);
   assign match = (value == ~inverse);
endmodule

// ==== verilog/ldc_params.svh ====
// laser drive configuration: offsets, field positions, reset values
// assumes a 32-bit apb slave, one register per aligned word
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH
// offsets are printed as word indices; byte address = 4 * index
`define LDC_IDX_MODE_CTRL   8'h1A
`define LDC_IDX_DRIVE       8'h1C
`define LDC_IDX_DRIVE_INV   8'h1D
`define LDC_IDX_RANGE_CMP   8'h1F
`define LDC_IDX_STATUS      8'h02
`define LDC_RST_MODE_CTRL   8'h00
`define LDC_RST_DRIVE       8'h00
`define LDC_RST_DRIVE_INV   8'h00
`define LDC_RST_RANGE_CMP   8'h01
`define LDC_BIT_RANGE       7
`define LDC_BIT_FIXED5      5
`define LDC_BIT_FORCE_OFF   0
`define LDC_CAL_LSB         1
`define LDC_CAL_MSB         3
`define LDC_BIT_VALID       6
// full-scale divisor of the drive dac, and its zero-code offset
`define LDC_DAC_FULL        9'h180
`define LDC_DAC_BASE        9'h081
`endif

// ==== verilog/ldc_top.sv ====
// laser drive configuration register bank with apb access
// assumes one 40 MHz clock and a synchronous active-low reset
//
// Added by the designer: register access over APB.
package ldc_pkg;
   typedef struct packed {
      logic [7:0] mode_ctrl;
      logic [7:0] drive;
      logic [7:0] drive_inv;
      logic [7:0] range_cmp;
      logic [31:0] prdata;
      logic        emit_en_n;
      logic        valid;
   } ldc_state_t;
endpackage

`include "ldc_params.svh"

module ldc_top (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic [7:0]       DAC_CODE,
   output logic [8:0]       DAC_REL_NUM,
   output logic             EMITTER_ENABLE_LOW,
   output logic [2:0]       CALIBRATION_SELECT,
   output logic             RANGE_HIGH,
   output logic             LASER_SETTING_VALID_FLAG
);
   // ***************************************************************
   // state
   // ***************************************************************
   ldc_pkg::ldc_state_t st_r;
   ldc_pkg::ldc_state_t st_nxt;
   logic                drive_ok;
   logic                range_ok;
   logic                acc;
   logic                setup;
   logic                wr;
   logic                pair_ok;
   logic [9:0]          idx;
   logic                hit;
   logic [7:0]          rd;

   ldc_cmp_check #(.W(8)) u_drive_chk (
      .value   (st_r.drive),
      .inverse (st_r.drive_inv),
      .match   (drive_ok)
   );
   ldc_cmp_check #(.W(1)) u_range_chk (
      .value   (st_r.mode_ctrl[`LDC_BIT_RANGE]),
      .inverse (st_r.range_cmp[`LDC_BIT_RANGE]),
      .match   (range_ok)
   );

   // ***************************************************************
   // apb decode
   // ***************************************************************
   assign acc   = PSEL && PENABLE;
   assign setup = PSEL && !PENABLE;
   assign wr  = acc && PWRITE;
   assign idx = PADDR[11:2];
   always_comb begin
      hit = 1'b1;
      rd  = 8'h00;
      if (PADDR[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (idx == 10'(`LDC_IDX_MODE_CTRL)) begin
         rd = st_r.mode_ctrl;
      end else if (idx == 10'(`LDC_IDX_DRIVE)) begin
         rd = st_r.drive;
      end else if (idx == 10'(`LDC_IDX_DRIVE_INV)) begin
         rd = st_r.drive_inv;
      end else if (idx == 10'(`LDC_IDX_RANGE_CMP)) begin
         rd = st_r.range_cmp;
      end else if (idx == 10'(`LDC_IDX_STATUS)) begin
         rd = {1'b0, st_r.valid, 6'h00};
      end else begin
         hit = 1'b0;
      end
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      st_nxt = st_r;
      // read word captured in setup so it already stands in access
      if (setup) begin
         st_nxt.prdata = {24'h000000, rd};
      end
      // each register stored independently, so write order is free
      if (wr && hit && idx == 10'(`LDC_IDX_MODE_CTRL)) begin
         st_nxt.mode_ctrl = PWDATA[7:0];
      end
      if (wr && hit && idx == 10'(`LDC_IDX_DRIVE)) begin
         st_nxt.drive = PWDATA[7:0];
      end
      if (wr && hit && idx == 10'(`LDC_IDX_DRIVE_INV)) begin
         st_nxt.drive_inv = PWDATA[7:0];
      end
      if (wr && hit && idx == 10'(`LDC_IDX_RANGE_CMP)) begin
         st_nxt.range_cmp = PWDATA[7:0];
      end
      // flag follows the registered pair, one cycle after the write
      st_nxt.valid = pair_ok;
      st_nxt.emit_en_n = !pair_ok
                         || st_r.mode_ctrl[`LDC_BIT_FORCE_OFF];
   end

   // both pairs must hold before the emitter may run
   assign pair_ok = drive_ok && range_ok;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_r.mode_ctrl <= `LDC_RST_MODE_CTRL;
         st_r.drive     <= `LDC_RST_DRIVE;
         st_r.drive_inv <= `LDC_RST_DRIVE_INV;
         st_r.range_cmp <= `LDC_RST_RANGE_CMP;
         st_r.prdata    <= 32'h00000000;
         st_r.emit_en_n <= 1'b1;
         st_r.valid     <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign PRDATA  = st_r.prdata;
   assign PREADY  = 1'b1;
   assign PSLVERR = acc && !hit;
   assign DAC_CODE = st_r.drive;
   // relative current = (129 + code) / 384 of full scale
   assign DAC_REL_NUM = 9'(`LDC_DAC_BASE + {1'b0, st_r.drive});
   assign EMITTER_ENABLE_LOW = st_r.emit_en_n;
   assign CALIBRATION_SELECT =
      st_r.mode_ctrl[`LDC_CAL_MSB:`LDC_CAL_LSB];
   assign RANGE_HIGH = st_r.mode_ctrl[`LDC_BIT_RANGE];
   assign LASER_SETTING_VALID_FLAG = st_r.valid;
endmodule
